// >>> rtl/hpt_defines.vh
// Register offsets, field positions, reset values and timing counts of the playback trigger block
// Assumes a 40 MHz core clock and an 8-bit register port from the host interface logic
`ifndef HPT_DEFINES_VH
`define HPT_DEFINES_VH
`define HPT_ADDR_SLOT0        8'h04
`define HPT_ADDR_SLOT7        8'h0B
`define HPT_ADDR_TRIGGER      8'h0C
`define HPT_ADDR_OVERDRIVE    8'h0D
`define HPT_ADDR_POS_SUSTAIN  8'h0E
`define HPT_ADDR_NEG_SUSTAIN  8'h0F
`define HPT_TRIGGER_BIT       0
`define HPT_SLOT_WAIT_BIT     7
`define HPT_RST_TRIGGER       8'h00
`define HPT_RST_OFFSET        8'h00
`define HPT_MODE_INT_TRIG     3'h0
`define HPT_MODE_EXT_EDGE     3'h1
`define HPT_MODE_EXT_LEVEL    3'h2
`define HPT_MODE_DIAG         3'h6
`define HPT_MODE_CALIB        3'h7
`define HPT_CLK_HZ            40000000
`define HPT_WAIT_UNIT_MS      10
`define HPT_WAIT_UNIT_CYC     ((`HPT_CLK_HZ / 1000) * `HPT_WAIT_UNIT_MS)
`define HPT_TICK_MS           5
`define HPT_TICK_CYC          ((`HPT_CLK_HZ / 1000) * `HPT_TICK_MS)
`endif

// >>> rtl/hpt_segment_timer.v
// Segment duration timer: counts a signed-adjusted number of playback ticks
// Assumes start is a one-cycle pulse from the trigger block on the same clock
`include "hpt_defines.vh"
module hpt_segment_timer #(
  parameter TICK_CYC = `HPT_TICK_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire        abort,
  input  wire [7:0]  nominal_ticks,
  input  wire [7:0]  offset,
  input  wire        use_offset,
  output wire        busy,
  output reg         done
);
  // Tick prescaler and remaining tick count
  reg  [31:0] pre_q;
  reg  [9:0]  left_q;
  reg         busy_q;
  wire signed [10:0] sum_w;

  // Signed sum of nominal length and offset; offset ignored while use_offset is low (overdrive segment in closed loop)
  assign sum_w = $signed({3'h0, nominal_ticks}) +
                 (use_offset ? $signed({{3{offset[7]}}, offset}) : 11'sh000);
  assign busy  = busy_q;

  // Count ticks; a negative result clamps to an empty segment, never wraps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= 32'h0;
      left_q <= 10'h000;
      busy_q <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
      end else if (start) begin
        left_q <= sum_w[10] ? 10'h000 : sum_w[9:0];
        pre_q  <= 32'h0;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (left_q == 10'h000) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end else if (pre_q == TICK_CYC - 1) begin
          pre_q  <= 32'h0;
          left_q <= left_q - 10'h001;
        end else begin
          pre_q <= pre_q + 32'h1;
        end
      end
    end
  end
endmodule

// >>> rtl/hpt_trigger_regs.v
// Playback trigger and segment offset registers with the sequence engine that they steer
// Assumes an 8-bit register port from the host interface, a waveform library outside that
// returns segment lengths per identifier, and a calibration/diagnostic engine outside.
//
// Functional notes
// - Trigger starts process chosen by mode
// - Sequence mode plays the eight slots
// - Trigger reads one until sequence ends
// - Writing zero aborts remaining sequence
// - External trigger sets or clears trigger
// - Calibration or diagnostics modes start those
// - Overdrive offset signed times tick period
// - Overdrive segment is the maximum value
// - Overdrive offset applies open loop only
// - Positive sustain offset scales positive segment
// - Negative sustain offset scales negative segment
// - Stop at zero identifier or slot eight
// - Wait slot idles ten milliseconds per unit (not done here: the wait flag is tied low and S_WAIT is never entered)
`include "hpt_defines.vh"
module hpt_trigger_regs #(
  parameter WAIT_CYC = `HPT_WAIT_UNIT_CYC,
  parameter TICK_CYC = `HPT_TICK_CYC
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire [2:0]  op_mode,
  input  wire        closed_loop,
  input  wire        ext_trig_pin,
  input  wire [55:0] slot_ids,
  output reg  [6:0]  wave_id,
  output reg  [1:0]  seg_kind,
  output reg         seg_active,
  output reg  [7:0]  lib_index,
  output reg         lib_req,
  input  wire [7:0]  lib_ticks,
  input  wire [1:0]  lib_kind,
  input  wire        lib_valid,
  input  wire        lib_last,
  output reg         calib_start,
  output reg         diag_start,
  input  wire        aux_done
);
  // Sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_SLOT = 3'h1;
  localparam S_FETCH = 3'h2;
  localparam S_SEG  = 3'h3;
  localparam S_WAIT = 3'h4;
  localparam S_AUX  = 3'h5;
  // Segment kinds from the library: overdrive, positive, negative, other
  localparam K_OD = 2'h0;
  localparam K_POS = 2'h1;
  localparam K_NEG = 2'h2;

  // Reset synchroniser and pin synchroniser
  reg  [1:0]  rst_sync_q;
  wire        rst_n;
  reg  [1:0]  trig_sync_q;
  reg         trig_prev_q;
  // Registers
  reg         go_q;
  reg  [7:0]  odt_q;
  reg  [7:0]  pos_q;
  reg  [7:0]  neg_q;
  reg  [2:0]  st_q;
  reg  [2:0]  slot_q;
  reg  [7:0]  seg_q;
  reg  [31:0] wcnt_q;
  reg  [6:0]  wunits_q;
  wire        t_start;   // Timer launch, same edge as the library answer
  wire        t_done;
  wire        t_busy;
  wire        abort_w;
  wire [7:0]  slot_w;
  wire        go_set;
  wire        go_clr;
  wire        trig_rise;
  wire        trig_fall;
  reg  [7:0]  offs_w;

  // Pick one slot byte by index
  function [7:0] slot_byte;
    input [55:0] ids;
    input [2:0]  idx;
    input        waitf;
    begin
      slot_byte = {1'b0, ids[idx*7 +: 7]};
      slot_byte[`HPT_SLOT_WAIT_BIT] = waitf;
    end
  endfunction

  // Release reset through two flip-flops
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Trigger pin passes two flops before any edge logic
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_q <= 2'b00;
      trig_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], ext_trig_pin};
      trig_prev_q <= trig_sync_q[1];
    end
  end
  assign trig_rise = trig_sync_q[1] & ~trig_prev_q;
  assign trig_fall = ~trig_sync_q[1] & trig_prev_q;

  // pin acts like a write
  // Edge mode only sets; level mode follows the pin both ways
  assign go_set = (reg_wr && reg_addr == `HPT_ADDR_TRIGGER && reg_wdata[`HPT_TRIGGER_BIT]) ||
                  ((op_mode == `HPT_MODE_EXT_EDGE || op_mode == `HPT_MODE_EXT_LEVEL) && trig_rise);
  assign go_clr = (reg_wr && reg_addr == `HPT_ADDR_TRIGGER && !reg_wdata[`HPT_TRIGGER_BIT]) ||
                  (op_mode == `HPT_MODE_EXT_LEVEL && trig_fall);
  assign abort_w = go_clr && go_q;
  // Each slot arrives as a 7-bit id only; the wait flag bit of the slot byte is tied to zero
  assign slot_w = slot_byte(slot_ids, slot_q, 1'b0);

  // Launch the timer while the library answer stands; the lines may change one cycle later
  assign t_start = (st_q == S_FETCH) && lib_valid;

  // Offset chosen by segment kind
  always @* begin
    case (lib_kind)
      K_OD:    offs_w = odt_q;
      K_POS:   offs_w = pos_q;
      K_NEG:   offs_w = neg_q;
      default: offs_w = 8'h00;
    endcase
  end

  // Offset registers, plain read/write
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      odt_q <= `HPT_RST_OFFSET;
      pos_q <= `HPT_RST_OFFSET;
      neg_q <= `HPT_RST_OFFSET;
    end else if (reg_wr) begin
      if (reg_addr == `HPT_ADDR_OVERDRIVE) odt_q <= reg_wdata;
      if (reg_addr == `HPT_ADDR_POS_SUSTAIN) pos_q <= reg_wdata;
      if (reg_addr == `HPT_ADDR_NEG_SUSTAIN) neg_q <= reg_wdata;
    end
  end

  // Read data registered one cycle after the read strobe; reserved bits read zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `HPT_ADDR_TRIGGER:     reg_rdata <= {7'h00, go_q};
        `HPT_ADDR_OVERDRIVE:   reg_rdata <= odt_q;
        `HPT_ADDR_POS_SUSTAIN: reg_rdata <= pos_q;
        `HPT_ADDR_NEG_SUSTAIN: reg_rdata <= neg_q;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // Sequence engine and trigger bit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q        <= 1'b0;
      st_q        <= S_IDLE;
      slot_q      <= 3'h0;
      seg_q       <= 8'h00;
      wcnt_q      <= 32'h0;
      wunits_q    <= 7'h00;
      wave_id     <= 7'h00;
      seg_kind    <= 2'h3;
      seg_active  <= 1'b0;
      lib_index   <= 8'h00;
      lib_req     <= 1'b0;
      calib_start <= 1'b0;
      diag_start  <= 1'b0;
    end else begin
      lib_req     <= 1'b0;
      calib_start <= 1'b0;
      diag_start  <= 1'b0;
      if (abort_w) begin
        go_q       <= 1'b0;
        st_q       <= S_IDLE;
        seg_active <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: begin
            if (go_set) begin
              go_q <= 1'b1;
              if (op_mode == `HPT_MODE_CALIB) begin
                calib_start <= 1'b1;
                st_q        <= S_AUX;
              end else if (op_mode == `HPT_MODE_DIAG) begin
                diag_start <= 1'b1;
                st_q       <= S_AUX;
              end else begin
                slot_q <= 3'h0;
                st_q   <= S_SLOT;
              end
            end
          end
          S_SLOT: begin
            if (slot_w[6:0] == 7'h00) begin
              go_q <= 1'b0;
              st_q <= S_IDLE;
            end else begin
              wave_id   <= slot_w[6:0];
              lib_index <= 8'h00;
              seg_q     <= 8'h00;
              lib_req   <= 1'b1;
              st_q      <= S_FETCH;
            end
          end
          S_FETCH: begin
            if (lib_valid) begin
              seg_kind   <= lib_kind;
              seg_active <= 1'b1;
              st_q       <= S_SEG;
            end
          end
          S_SEG: begin
            if (t_done) begin
              seg_active <= 1'b0;
              if (lib_last) begin
                // next slot or finish after eight
                if (slot_q == 3'h7) begin
                  go_q <= 1'b0;
                  st_q <= S_IDLE;
                end else begin
                  slot_q <= slot_q + 3'h1;
                  st_q   <= S_SLOT;
                end
              end else begin
                lib_index <= lib_index + 8'h01;
                lib_req   <= 1'b1;
                st_q      <= S_FETCH;
              end
            end
          end
          S_WAIT: begin
            if (wunits_q == 7'h00) begin
              st_q <= (slot_q == 3'h7) ? S_IDLE : S_SLOT;
              go_q <= (slot_q != 3'h7);
              slot_q <= slot_q + 3'h1;
            end else if (wcnt_q == WAIT_CYC - 1) begin
              wcnt_q   <= 32'h0;
              wunits_q <= wunits_q - 7'h01;
            end else begin
              wcnt_q <= wcnt_q + 32'h1;
            end
          end
          S_AUX: begin
            if (aux_done) begin
              go_q <= 1'b0;
              st_q <= S_IDLE;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  hpt_segment_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk           (sys_clk),
    .rst_n         (rst_n),
    .start         (t_start),
    .abort         (abort_w),
    .nominal_ticks (lib_ticks),
    .offset        (offs_w),
    .use_offset    (!(closed_loop && lib_kind == K_OD)),
    .busy          (t_busy),
    .done          (t_done)
  );
endmodule

// >>> bench/hpt_trigger_regs_asserts.sv
// Port checker for the trigger block
// Assumes one clock and the async low reset
module hpt_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] op_mode,
  input wire logic [6:0] wave_id,
  input wire logic       lib_req,
  input wire logic       calib_start,
  input wire logic       diag_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Aux starts only in their own mode; diag start a lone pulse; no playback for four cycles from a calib start
  a_calib_mode_match: assert property (calib_start |-> op_mode == 3'h7) else $error("calib mode");
  a_diag_mode_match: assert property (diag_start |-> op_mode == 3'h6) else $error("diag mode");
  a_diag_single_pulse: assert property (diag_start |=> !diag_start) else $error("diag pulse");
  a_aux_no_play: assert property (calib_start |-> !lib_req [*4]) else $error("aux played");
  // Playback only in the trigger modes, never past a zero id
  a_play_mode_match: assert property (lib_req |-> op_mode < 3'h3) else $error("play mode");
  a_zero_id_stop: assert property (lib_req |-> wave_id != 7'h00) else $error("zero id");
  // Reserved bits read zero; answers stand until the next read
  a_trig_reserved_zero: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved bits");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  c_calib: cover property (calib_start);
  c_diag: cover property (diag_start);
  c_play: cover property (lib_req ##[1:300] lib_req);
endmodule
bind hpt_trigger_regs hpt_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .op_mode(op_mode), .wave_id(wave_id), .lib_req(lib_req),
  .calib_start(calib_start), .diag_start(diag_start));

// >>> bench/hpt_lib_model.sv
// Waveform library stand-in answering segment requests
// Assumes lib_req is a one-cycle pulse
module hpt_lib_model (
  input  wire logic       sys_clk,
  input  wire logic       lib_req,
  input  wire logic [7:0] lib_index,
  input  int              delay_cyc,
  output logic      [7:0] lib_ticks = 8'h00,
  output logic      [1:0] lib_kind = 2'h0,
  output logic            lib_valid = 1'b0,
  output logic            lib_last = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;  // Cycles to the answer, -1 idle
  // Lines churn outside the answer so stale data never looks good
  always @(posedge sys_clk) begin
    lib_valid <= 1'b0;
    lib_ticks <= ~lib_ticks;
    lib_kind <= ~lib_kind;
    lib_last <= ~lib_last;
    if (lib_req)
      cnt <= delay_cyc;
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0) begin
      cnt <= -1;
      lib_valid <= 1'b1;
      lib_ticks <= 8'h03;
      lib_kind <= {1'b0, lib_index[0]};
      lib_last <= 1'b1;
    end
  end
endmodule

// >>> bench/hpt_trigger_regs_tb.sv
// Self-checking bench for the trigger block
// Assumes the block, checker and library model
module hpt_trigger_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic closed_loop = 1'b0, ext_trig_pin = 1'b0, aux_done = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lib_index, lib_ticks, v;
  logic [2:0] op_mode = 3'h0;
  logic [55:0] slot_ids = 56'h0;
  logic [6:0] wave_id;
  logic [1:0] seg_kind, lib_kind;
  logic seg_active, lib_req, lib_valid, lib_last, calib_start, diag_start;
  logic [8:0] rq[$];  // Expected reads, bit 8 set when checked
  logic [7:0] wq[$];  // Expected ids in request order
  logic [7:0] aq[$];  // Expected aux start, 1 calib, 2 diag
  int n_mismatch = 0, comparisons = 0, delay_cyc = 2, i, k;
  int seed = 32'h8BED11F9;
  logic seg_prev = 1'b0;
  logic [7:0] odt_v = 8'h00;  // Overdrive offset as written
  int seg_cyc = 0, seg_exp;
  always #12.5 sys_clk = ~sys_clk;
  hpt_trigger_regs #(.WAIT_CYC(4), .TICK_CYC(2)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_mode(op_mode),
    .closed_loop(closed_loop), .ext_trig_pin(ext_trig_pin), .slot_ids(slot_ids), .wave_id(wave_id),
    .seg_kind(seg_kind), .seg_active(seg_active), .lib_index(lib_index), .lib_req(lib_req),
    .lib_ticks(lib_ticks), .lib_kind(lib_kind), .lib_valid(lib_valid), .lib_last(lib_last),
    .calib_start(calib_start), .diag_start(diag_start), .aux_done(aux_done));
  hpt_lib_model u_lib (.sys_clk(sys_clk), .lib_req(lib_req), .lib_index(lib_index), .delay_cyc(delay_cyc),
    .lib_ticks(lib_ticks), .lib_kind(lib_kind), .lib_valid(lib_valid), .lib_last(lib_last));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // Answer stands from the edge after the strobe
  task automatic rd(logic [7:0] a, logic [8:0] e);
    rq.push_back(e);
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask
  // Random nonzero ids, slot n zeroed so later ids must never play
  task automatic load(int n);
    for (int j = 0; j < 8; j++) begin
      v = 8'($random(seed)) | 8'h01;
      slot_ids[7*j+:7] = (j == n) ? 7'h00 : v[6:0];
      if (j < n)
        wq.push_back({1'b0, v[6:0]});
    end
  endtask
  task automatic wait_idle();
    for (k = 0; k < 3000; k++) begin
      rd(8'h0C, 9'h000);
      if (reg_rdata === 8'h00)
        return;
    end
    chk("trigger_clear", 8'h00, reg_rdata);
    report_and_stop();
  endtask
  // Slow library keeps slot 0 busy while the trigger drops
  task automatic abort(logic [2:0] m);
    op_mode = m;
    delay_cyc = 30;
    load(8);
    wq = wq[0:0];
    if (m == 3'h0)
      wr(8'h0C, 8'h01);
    else
      ext_trig_pin = 1'b1;
    repeat (12) @(negedge sys_clk);
    if (m == 3'h0)
      wr(8'h0C, 8'h00);
    else
      ext_trig_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    rd(8'h0C, 9'h100);
    repeat (40) @(negedge sys_clk);
  endtask
  // Each result is matched with the oldest note of its kind
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen && rq.size() > 0 && rq[0][8])
      chk("reg_rdata", rq[0][7:0], reg_rdata);
    if (rd_seen && rq.size() > 0)
      void'(rq.pop_front());
    if (lib_req)
      chk("wave_id", wq.size() > 0 ? wq.pop_front() : 8'hXX, {1'b0, wave_id});
    if (calib_start || diag_start)
      chk("aux_start", aq.size() > 0 ? aq.pop_front() : 8'hXX, {6'h00, diag_start, calib_start});
    // Segment of 3 ticks, plus the overdrive offset in open loop, each tick 2 cycles, plus load and done cycles
    if (!seg_active && seg_prev) begin
      seg_exp = closed_loop ? 3 : 3 + int'($signed(odt_v));
      chk("seg_len", 8'(2 * (seg_exp < 0 ? 0 : seg_exp) + 2), 8'(seg_cyc));
      chk("seg_kind", 8'h00, {6'h00, seg_kind});
      seg_cyc = 0;
    end
    if (seg_active)
      seg_cyc++;
    seg_prev = seg_active;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    chk("watchdog", 8'h00, 8'h01);
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (i = 12; i < 16; i++)
      rd(8'(i), 9'h100);
    for (i = 13; i < 16; i++) begin
      v = 8'($random(seed));
      if (i == 13)
        odt_v = v;
      wr(8'(i), v);
      rd(8'(i), {1'b1, v});
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 9'h100);
    wr(8'h0C, 8'hFE);
    rd(8'h0C, 9'h100);
    // Full eight slots, then a zero id after two
    for (i = 0; i < 2; i++) begin
      closed_loop = 1'($random(seed));
      load(i ? 2 : 8);
      wr(8'h0C, 8'h01);
      rd(8'h0C, 9'h101);
      wait_idle();
    end
    abort(3'h0);
    abort(3'h2);
    op_mode = 3'h1;
    delay_cyc = 8;
    load(1);
    ext_trig_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h0C, 9'h101);
    ext_trig_pin = 1'b0;
    wait_idle();
    for (i = 6; i < 8; i++) begin
      op_mode = 3'(i);
      aq.push_back(i == 7 ? 8'h01 : 8'h02);
      wr(8'h0C, 8'h01);
      rd(8'h0C, 9'h101);
      aux_done = 1'b1;
      @(negedge sys_clk);
      aux_done = 1'b0;
      wait_idle();
    end
    op_mode = 3'h0;
    chk("notes_left", 8'h00, 8'(wq.size() + aq.size()));
    report_and_stop();
  end
endmodule
